// [verilog/fsf_pkg.sv]
// Purpose: Shared constants for the FIFO flag and expansion block
// Assumes: Single clock, classic Wishbone register access
// Notes:   Offsets are byte addresses of 32-bit words
package fsf_pkg;
  localparam int          DATA_W       = 18;
  localparam int          OFS_W        = 12;
  localparam int          CNT_W        = 13;
  localparam int          ADR_W        = 8;
  localparam int          DEPTH_DEF    = 256;
  localparam int          DEPTH_SMALL  = 256;
  localparam int          DEPTH_MID    = 512;
  localparam logic [11:0] DEF_OFS_SMALL = 12'h001F;
  localparam logic [11:0] DEF_OFS_MID   = 12'h003F;
  localparam logic [11:0] DEF_OFS_LARGE = 12'h007F;

  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_EMPTY_OFS = 8'h08;
  localparam logic [7:0]  REG_FULL_OFS = 8'h0C;

  localparam int          CTRL_FLUSH_BIT = 0;
  localparam int          ST_EMPTY_BIT  = 16;
  localparam int          ST_FULL_BIT   = 17;
  localparam int          ST_AE_BIT     = 18;
  localparam int          ST_AF_BIT     = 19;
  localparam int          ST_HF_BIT     = 20;
  localparam int          ST_DAISY_BIT  = 21;
  localparam int          ST_WOWN_BIT   = 22;
  localparam int          ST_ROWN_BIT   = 23;

  localparam logic [17:0] DATA_ZERO    = 18'h0_0000;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

  // Default almost-flag distance per depth variant
  function automatic logic [11:0] def_offset(input int depth);
    if (depth <= DEPTH_SMALL) begin
      return DEF_OFS_SMALL;
    end else if (depth <= DEPTH_MID) begin
      return DEF_OFS_MID;
    end else begin
      return DEF_OFS_LARGE;
    end
  endfunction : def_offset

  // Byte-lane merge of a 12-bit register from a bus write
  function automatic logic [11:0] lane_merge(input logic [11:0] old_v,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [11:0] v;
    v = old_v;
    if (sel[0]) begin
      v[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      v[11:8] = wdat[11:8];
    end
    return v;
  endfunction : lane_merge
endpackage : fsf_pkg

// [verilog/fsf_mem_if.sv]
// Purpose: Carrier between FIFO control and its storage array
// Assumes: One write port, one asynchronous read port
// Notes:   Width and address size follow the parameters
`timescale 1ns/1ps
`default_nettype none
interface fsf_mem_if #(
  parameter int DW = 18,
  parameter int AW = 8
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : fsf_mem_if
`default_nettype wire

// [verilog/fsf_mem.sv]
// Purpose: Flip-flop storage array of the FIFO
// Assumes: Write on clock edge, read combinational by index
// Notes:   No reset on storage; contents are don't-care until written
`timescale 1ns/1ps
`default_nettype none
module fsf_mem #(
  parameter int DW    = 18,
  parameter int DEPTH = 256
) (
  input wire logic clk,
  fsf_mem_if.mem   port
);
  logic [DW-1:0] store_q [DEPTH];

  always_ff @(posedge clk) begin
    if (port.we) begin
      store_q[port.waddr] <= port.wdata;
    end
  end

  assign port.rdata = store_q[port.raddr];
endmodule : fsf_mem
`default_nettype wire

// [verilog/fsf_top.sv]
// Purpose: FIFO with status flags, offset registers and chain expansion
// Assumes: Write and read sides share clk; partner logic on same clock
// Notes:   Flags are registered from next occupancy, so guards are exact
// Summary of operation
// - Almost-full low at depth minus full offset
// - Unprogrammed full offset defaults per depth
// - Almost-full falls on write, rises on read
// - Almost-empty low at n plus one trailing; almost_empty_n goes low at n words or fewer
// - Unprogrammed empty offset defaults per depth
// - Empty: full, almost-full, half high; others low
// - Half-full low above half depth, rises later
// - Half-full on chain pin only in single mode
// - Pulse write chain out at last location
// - Pulse read chain out at last location
// - Outputs zero after reset; disable only drives read_data_oe_n high, no tristate
// - Full release may slip one write edge
// - Empty release may slip one read edge
// - First word readable cycle after empty rises
// - First read latency one or two cycles
// - No half-full indication in daisy chain; status register bit 20 still reports it
// - Clocks may run during reset
// - Reset clears pointers, flags, output; loads default offsets
// - Two 12-bit offsets from low data bits
// - Load writes alternate empty then full offset
// - Load reads use separate selection pointer
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module fsf_top #(
  parameter int DEPTH = fsf_pkg::DEPTH_DEF
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [fsf_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        wr_en_n,
  input  wire logic [fsf_pkg::DATA_W-1:0]  write_data,
  input  wire logic                        rd_en_n,
  input  wire logic                        offset_load_n,
  input  wire logic                        output_enable_n,
  input  wire logic                        first_device_sel_n,
  input  wire logic                        wr_chain_in_n,
  input  wire logic                        rd_chain_in_n,
  output logic      [fsf_pkg::DATA_W-1:0]  read_data,
  output logic                             read_data_oe_n,
  output logic                             full_n,
  output logic                             empty_n,
  output logic                             almost_full_n,
  output logic                             almost_empty_n,
  output logic                             wr_chain_out_n,
  output logic                             rd_chain_out_n
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [fsf_pkg::CNT_W-1:0] DEPTH_C = fsf_pkg::CNT_W'(DEPTH);
  localparam logic [fsf_pkg::CNT_W-1:0] HALF_C  = fsf_pkg::CNT_W'(DEPTH / 2);
  localparam logic [AW-1:0]             LAST_C  = AW'(DEPTH - 1);
  localparam logic [11:0]               DEF_OFS = fsf_pkg::def_offset(DEPTH);

  function automatic logic adr_hit(input logic [fsf_pkg::ADR_W-1:0] adr,
                                   input logic [fsf_pkg::ADR_W-1:0] reg_adr);
    return adr == reg_adr;
  endfunction : adr_hit

  fsf_mem_if #(.DW(fsf_pkg::DATA_W), .AW(AW)) mem_bus ();

  fsf_mem #(.DW(fsf_pkg::DATA_W), .DEPTH(DEPTH)) u_mem (
    .clk  (clk),
    .port (mem_bus.mem)
  );

  logic [AW:0]                 wptr_q;
  logic [AW:0]                 rptr_q;
  logic [AW:0]                 wptr_d;
  logic [AW:0]                 rptr_d;
  logic [fsf_pkg::CNT_W-1:0]   occ_d;
  logic [fsf_pkg::CNT_W-1:0]   occ_q;
  logic [11:0]                 empty_ofs_q;
  logic [11:0]                 full_ofs_q;
  logic                        wsel_q;
  logic                        rsel_q;
  logic [fsf_pkg::DATA_W-1:0]  data_q;
  logic                        full_n_q;
  logic                        empty_n_q;
  logic                        af_n_q;
  logic                        ae_n_q;
  logic                        hf_n_q;
  logic                        cfg_done_q;
  logic                        daisy_q;
  logic                        wr_own_q;
  logic                        rd_own_q;
  logic                        wpulse_q;
  logic                        rpulse_q;
  logic                        ack_q;
  logic [31:0]                 rdat_q;
  logic                        wb_req;
  logic                        wb_wr;
  logic                        flush;
  logic                        do_wr;
  logic                        do_rd;
  logic                        ofs_wr;
  logic                        ofs_rd;
  logic                        hit_ctrl;
  logic                        hit_status;
  logic                        hit_empty_ofs;
  logic                        hit_full_ofs;
  logic [AW:0]                 occ_w;

  // Bus request is served on the cycle ack rises
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr  = wb_req & wb_we_i;
  // Address decode shared by bus writes and reads
  assign hit_ctrl      = adr_hit(wb_adr_i, fsf_pkg::REG_CTRL);
  assign hit_status    = adr_hit(wb_adr_i, fsf_pkg::REG_STATUS);
  assign hit_empty_ofs = adr_hit(wb_adr_i, fsf_pkg::REG_EMPTY_OFS);
  assign hit_full_ofs  = adr_hit(wb_adr_i, fsf_pkg::REG_FULL_OFS);
  assign flush  = wb_wr & hit_ctrl & wb_sel_i[0]
                  & wb_dat_i[fsf_pkg::CTRL_FLUSH_BIT];

  // Writes gated by full flag and chain ownership; nothing before strap capture
  assign do_wr  = cfg_done_q & offset_load_n & ~wr_en_n & full_n_q & wr_own_q;
  assign do_rd  = cfg_done_q & offset_load_n & ~rd_en_n & empty_n_q & rd_own_q;
  assign ofs_wr = cfg_done_q & ~offset_load_n & ~wr_en_n;
  assign ofs_rd = cfg_done_q & ~offset_load_n & ~rd_en_n;

  assign mem_bus.we    = do_wr;
  assign mem_bus.waddr = wptr_q[AW-1:0];
  assign mem_bus.wdata = write_data;
  assign mem_bus.raddr = rptr_q[AW-1:0];

  always_comb begin
    wptr_d = wptr_q + (AW+1)'(do_wr);
    rptr_d = rptr_q + (AW+1)'(do_rd);
    if (flush) begin
      wptr_d = '0;
      rptr_d = '0;
    end
    // Difference kept at pointer width so it wraps modulo twice the depth
    occ_w = wptr_d - rptr_d;
    occ_d = fsf_pkg::CNT_W'(occ_w);
  end

  // Pointers; clocks may keep running while reset holds them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      occ_q  <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      occ_q  <= occ_d;
    end
  end

  // Flags from next occupancy; one shared clock means no skew slip
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      full_n_q  <= 1'b1;
      af_n_q    <= 1'b1;
      hf_n_q    <= 1'b1;
      empty_n_q <= 1'b0;
      ae_n_q    <= 1'b0;
    end else begin
      full_n_q  <= (occ_d != DEPTH_C);
      empty_n_q <= (occ_d != '0);
      af_n_q    <= (occ_d < (DEPTH_C - {1'b0, full_ofs_q}));
      ae_n_q    <= (occ_d > {1'b0, empty_ofs_q});
      hf_n_q    <= (occ_d <= HALF_C);
    end
  end

  // Mode strap caught on first clock after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_done_q <= 1'b0;
      daisy_q    <= 1'b0;
    end else if (!cfg_done_q) begin
      cfg_done_q <= 1'b1;
      daisy_q    <= wr_chain_in_n | rd_chain_in_n;
    end
  end

  // Write ownership token passed down the chain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_own_q <= 1'b0;
      wpulse_q <= 1'b0;
    end else begin
      wpulse_q <= 1'b0;
      if (!cfg_done_q) begin
        wr_own_q <= ~(wr_chain_in_n | rd_chain_in_n) | ~first_device_sel_n;
      end else if (daisy_q && do_wr && wptr_q[AW-1:0] == LAST_C) begin
        wr_own_q <= 1'b0;
        wpulse_q <= 1'b1;
      end else if (daisy_q && !wr_chain_in_n) begin
        wr_own_q <= 1'b1;
      end
    end
  end

  // Read ownership token passed down the chain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_own_q <= 1'b0;
      rpulse_q <= 1'b0;
    end else begin
      rpulse_q <= 1'b0;
      if (!cfg_done_q) begin
        rd_own_q <= ~(wr_chain_in_n | rd_chain_in_n) | ~first_device_sel_n;
      end else if (daisy_q && do_rd && rptr_q[AW-1:0] == LAST_C) begin
        rd_own_q <= 1'b0;
        rpulse_q <= 1'b1;
      end else if (daisy_q && !rd_chain_in_n) begin
        rd_own_q <= 1'b1;
      end
    end
  end

  // Offset registers; bus access takes priority over pin load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      empty_ofs_q <= DEF_OFS;
      full_ofs_q  <= DEF_OFS;
      wsel_q      <= 1'b0;
    end else if (wb_wr && hit_empty_ofs) begin
      empty_ofs_q <= fsf_pkg::lane_merge(empty_ofs_q, wb_dat_i, wb_sel_i);
    end else if (wb_wr && hit_full_ofs) begin
      full_ofs_q <= fsf_pkg::lane_merge(full_ofs_q, wb_dat_i, wb_sel_i);
    end else if (ofs_wr) begin
      if (wsel_q) begin
        full_ofs_q <= write_data[fsf_pkg::OFS_W-1:0];
      end else begin
        empty_ofs_q <= write_data[fsf_pkg::OFS_W-1:0];
      end
      wsel_q <= ~wsel_q;
    end
  end

  // Output register: FIFO word or offset readback
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= fsf_pkg::DATA_ZERO;
      rsel_q <= 1'b0;
    end else if (do_rd) begin
      data_q <= mem_bus.rdata;
    end else if (ofs_rd) begin
      data_q <= fsf_pkg::DATA_W'(rsel_q ? full_ofs_q : empty_ofs_q);
      rsel_q <= ~rsel_q;
    end
  end

  assign read_data      = data_q;
  assign read_data_oe_n = output_enable_n;
  assign full_n         = full_n_q;
  assign empty_n        = empty_n_q;
  assign almost_full_n  = af_n_q;
  assign almost_empty_n = ae_n_q;
  // Shared pin loses half-full in chain mode
  assign wr_chain_out_n = daisy_q ? ~wpulse_q : hf_n_q;
  assign rd_chain_out_n = ~rpulse_q;

  // Wishbone slave, one-cycle answer; unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q  <= 1'b0;
      rdat_q <= fsf_pkg::WORD_ZERO;
    end else begin
      ack_q  <= wb_req;
      rdat_q <= fsf_pkg::WORD_ZERO;
      if (wb_req && !wb_we_i) begin
        if (hit_status) begin
          rdat_q[fsf_pkg::CNT_W-1:0]     <= occ_q;
          rdat_q[fsf_pkg::ST_EMPTY_BIT] <= empty_n_q;
          rdat_q[fsf_pkg::ST_FULL_BIT]  <= full_n_q;
          rdat_q[fsf_pkg::ST_AE_BIT]    <= ae_n_q;
          rdat_q[fsf_pkg::ST_AF_BIT]    <= af_n_q;
          rdat_q[fsf_pkg::ST_HF_BIT]    <= hf_n_q;
          rdat_q[fsf_pkg::ST_DAISY_BIT] <= daisy_q;
          rdat_q[fsf_pkg::ST_WOWN_BIT]  <= wr_own_q;
          rdat_q[fsf_pkg::ST_ROWN_BIT]  <= rd_own_q;
        end else if (hit_empty_ofs) begin
          rdat_q[fsf_pkg::OFS_W-1:0] <= empty_ofs_q;
        end else if (hit_full_ofs) begin
          rdat_q[fsf_pkg::OFS_W-1:0] <= full_ofs_q;
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
endmodule : fsf_top
`default_nettype wire

// [testbench/fsf_top_monitor.sv]
// Purpose: Port-level checks of the FIFO flag block
// Assumes: One clock, reset active high
// Notes:   Attached to every fsf_top instance by bind
`timescale 1ns/1ps
`default_nettype none
module fsf_top_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_ack_o,
  input wire logic        wr_en_n,
  input wire logic        rd_en_n,
  input wire logic        offset_load_n,
  input wire logic        output_enable_n,
  input wire logic [17:0] read_data,
  input wire logic        read_data_oe_n,
  input wire logic        full_n,
  input wire logic        empty_n,
  input wire logic        almost_full_n,
  input wire logic        almost_empty_n,
  input wire logic        rd_chain_out_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_full_blocks: assert property (!full_n && rd_en_n |=> !full_n)
    else $error("full flag released without a read");
  a_empty_blocks: assert property (!empty_n && wr_en_n |=> !empty_n)
    else $error("empty flag released without a write");
  a_first_word: assert property (!empty_n && !wr_en_n && offset_load_n && rd_en_n |=> empty_n)
    else $error("write into empty fifo not visible next cycle");
  a_read_refused: assert property (!empty_n && offset_load_n |=> $stable(read_data))
    else $error("read data changed while empty");
  a_af_before_full: assert property ($fell(full_n) |-> !almost_full_n)
    else $error("full reached without almost full");
  a_ae_at_empty: assert property ($fell(empty_n) |-> !almost_empty_n)
    else $error("empty reached without almost empty");
  a_af_by_write: assert property ($fell(almost_full_n) |-> !$past(wr_en_n))
    else $error("almost full fell without a write");
  a_af_by_read: assert property ($rose(almost_full_n) |-> !$past(rd_en_n))
    else $error("almost full rose without a read");
  a_rxo_pulse: assert property (!rd_chain_out_n |=> rd_chain_out_n)
    else $error("read chain pulse longer than one cycle");
  a_oe_track: assert property (read_data_oe_n == output_enable_n)
    else $error("output enable not followed");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  c_full: cover property (!full_n);
  c_rxo: cover property (!rd_chain_out_n);
  c_ack: cover property (wb_ack_o);
endmodule : fsf_top_monitor

bind fsf_top fsf_top_monitor mon (.*);
`default_nettype wire

// [testbench/fsf_peer.sv]
// Purpose: Writer and reader logic facing the FIFO pins
// Assumes: Same clock as the FIFO, requests one cycle after go
// Notes:   Data counts up per accepted write, so order is checkable
`timescale 1ns/1ps
`default_nettype none
module fsf_peer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_go,
  input  wire logic        rd_go,
  input  wire logic        ld_go,
  input  wire logic        daisy,
  input  wire logic [11:0] ld_val,
  input  wire logic        full_n,
  output logic             wr_en_n,
  output logic             rd_en_n,
  output logic             offset_load_n,
  output logic [17:0]      write_data,
  output logic             first_device_sel_n,
  output logic             wr_chain_in_n,
  output logic             rd_chain_in_n
);
  logic [17:0] wcnt_q;
  logic [11:0] ld_q;
  // First device in a chain, or single device
  assign first_device_sel_n = 1'b0;
  // Chain inputs idle high when chained, grounded when single
  assign wr_chain_in_n = daisy;
  assign rd_chain_in_n = daisy;
  assign write_data = offset_load_n ? wcnt_q : {6'h00, ld_q};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_en_n <= 1'b1;
      rd_en_n <= 1'b1;
      offset_load_n <= 1'b1;
      wcnt_q <= 18'h0_0000;
      ld_q <= 12'h000;
    end else begin
      wr_en_n <= !wr_go;
      rd_en_n <= !rd_go;
      offset_load_n <= !ld_go;
      ld_q <= ld_val;
      // Count only what the FIFO can take
      // Composite full of a one-device bank is that device's own flag
      if (!wr_en_n && full_n && offset_load_n) begin
        wcnt_q <= wcnt_q + 18'h0_0001;
      end
    end
  end
endmodule : fsf_peer
`default_nettype wire

// [testbench/fsf_top_bench.sv]
// Purpose: Self-checking bench for the FIFO flag block
// Assumes: One clock, depth cut to 64 so defaults stay meaningful
// Notes:   Partner model makes all FIFO and offset pin traffic
`timescale 1ns/1ps
`default_nettype none
module fsf_top_bench;
  localparam int D = 64;
  logic        clk = 1'b0, rst = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd_v;
  logic        output_enable_n = 1'b0, read_data_oe_n;
  logic        wr_go = 1'b0, rd_go = 1'b0, ld_go = 1'b0, daisy = 1'b0;
  logic [11:0] ld_val = 12'h000;
  logic [17:0] write_data, read_data;
  logic        wr_en_n, rd_en_n, offset_load_n, first_device_sel_n;
  logic        wr_chain_in_n, rd_chain_in_n, wr_chain_out_n, rd_chain_out_n;
  logic        full_n, empty_n, almost_full_n, almost_empty_n;
  int          fail_count = 0, n_checks = 0, wlow = 0, rlow = 0, w0, r0;

  fsf_top #(.DEPTH(D)) dut (.*);
  fsf_peer peer (.*);

  always #20 clk = ~clk;
  always @(posedge clk) begin
    wlow <= wlow + int'(!wr_chain_out_n);
    rlow <= rlow + int'(!rd_chain_out_n);
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t %s got %h want %h", $time, s, g, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd_v = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) chk(1'b0, 1'b1, "no ack");
  endtask : wb

  task automatic step(input logic w, input logic r, input logic l);
    @(posedge clk);
    wr_go <= w;
    rd_go <= r;
    ld_go <= l;
    @(posedge clk);
    wr_go <= 1'b0;
    rd_go <= 1'b0;
    ld_go <= 1'b0;
    @(posedge clk);
    #1;
  endtask : step

  task automatic flags(input int o, input int n, input int m, input bit one);
    chk(full_n, o != D, "full");
    chk(empty_n, o != 0, "empty");
    chk(almost_full_n, o < D - m, "almost full");
    chk(almost_empty_n, o > n, "almost empty");
    if (one) chk(wr_chain_out_n, o <= D / 2, "half");
  endtask : flags

  task automatic do_reset(input logic dz);
    @(posedge clk);
    rst <= 1'b1;
    daisy <= dz;
    repeat (5) @(posedge clk);
    chk({full_n, almost_full_n, wr_chain_out_n, empty_n, almost_empty_n}, 5'h1C, "rst");
    chk(read_data, 18'h0_0000, "rst data");
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic s_regs;
    wb(1'b0, fsf_pkg::REG_EMPTY_OFS, 32'h0000_0000);
    chk(rd_v, {20'h0_0000, fsf_pkg::DEF_OFS_SMALL}, "default n");
    wb(1'b0, fsf_pkg::REG_FULL_OFS, 32'h0000_0000);
    chk(rd_v, {20'h0_0000, fsf_pkg::DEF_OFS_SMALL}, "default m");
    wb(1'b1, 8'h40, 32'h0000_0ABC);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd_v, 32'h0000_0000, "unmapped");
    @(posedge clk);
    ld_go <= 1'b1;
    wr_go <= 1'b1;
    ld_val <= 12'h005;
    @(posedge clk);
    ld_val <= 12'h006;
    @(posedge clk);
    ld_go <= 1'b0;
    wr_go <= 1'b0;
    wb(1'b0, fsf_pkg::REG_EMPTY_OFS, 32'h0000_0000);
    chk(rd_v, 32'h0000_0005, "load n");
    wb(1'b0, fsf_pkg::REG_FULL_OFS, 32'h0000_0000);
    chk(rd_v, 32'h0000_0006, "load m");
    wb(1'b1, fsf_pkg::REG_FULL_OFS, 32'h0000_0007);
    wb(1'b0, fsf_pkg::REG_FULL_OFS, 32'h0000_0000);
    chk(rd_v, 32'h0000_0007, "bus m");
    step(1'b0, 1'b1, 1'b1);
    chk(read_data, 18'h0_0005, "readback");
    @(posedge clk);
    output_enable_n <= 1'b1;
    @(posedge clk);
    chk(read_data_oe_n, 1'b1, "oe");
    output_enable_n <= 1'b0;
  endtask : s_regs

  task automatic s_stream;
    for (int i = 1; i <= D + 1; i++) begin
      step(1'b1, 1'b0, 1'b0);
      flags(i > D ? D : i, 5, 7, 1'b1);
    end
    for (int i = 0; i <= D; i++) begin
      step(1'b0, 1'b1, 1'b0);
      chk(read_data, 18'(i < D ? i : D - 1), "order");
      flags(i < D ? D - 1 - i : 0, 5, 7, 1'b1);
    end
  endtask : s_stream

  // Write then read on the very next edge at the empty boundary
  task automatic s_first;
    @(posedge clk);
    wr_go <= 1'b1;
    @(posedge clk);
    wr_go <= 1'b0;
    rd_go <= 1'b1;
    @(posedge clk);
    rd_go <= 1'b0;
    @(posedge clk);
    #1;
    chk(read_data, 18'(D), "first word");
    chk(empty_n, 1'b0, "empty again");
    step(1'b1, 1'b0, 1'b0);
    wb(1'b0, fsf_pkg::REG_STATUS, 32'h0000_0000);
    chk(rd_v[fsf_pkg::CNT_W-1:0], 32'h0000_0001, "status count");
    chk(rd_v[fsf_pkg::ST_EMPTY_BIT], 1'b1, "status empty");
    wb(1'b1, fsf_pkg::REG_CTRL, 32'h0000_0001);
    flags(0, 5, 7, 1'b1);
  endtask : s_first

  task automatic s_daisy;
    do_reset(1'b1);
    w0 = wlow;
    for (int i = 1; i <= D; i++) begin
      step(1'b1, 1'b0, 1'b0);
      flags(i, 31, 31, 1'b0);
    end
    @(posedge clk);
    #1;
    chk(wlow - w0, 1, "write chain pulse");
    r0 = rlow;
    for (int i = 0; i < D; i++) begin
      step(1'b0, 1'b1, 1'b0);
      chk(read_data, 18'(i), "chain order");
    end
    @(posedge clk);
    #1;
    chk(rlow - r0, 1, "read chain pulse");
  endtask : s_daisy

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    do_reset(1'b0);
    s_regs();
    s_stream();
    s_first();
    s_daisy();
    give_verdict();
  end

  // Run needs about 850 cycles; allow over twenty times that
  initial begin
    #800_000;
    fail_count++;
    give_verdict();
  end
endmodule : fsf_top_bench
`default_nettype wire
